// File: include/cpm_map.svh
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// ==========================================================================
// Register offsets (word index on the register port)
// ==========================================================================
`define CPM_ADDR_W          4
`define CPM_DATA_W          16
`define CPM_PINS            8
`define CPM_OFS_OUTSEL      4'h0
`define CPM_OFS_PUD         4'h1
`define CPM_OFS_ENABLE      4'h2
`define CPM_OFS_DIR         4'h3
`define CPM_OFS_DATA        4'h4
`define CPM_OFS_SET         4'h5
`define CPM_OFS_CLEAR       4'h6
`define CPM_OFS_TOGGLE      4'h7

// ==========================================================================
// Reset values
// ==========================================================================
`define CPM_RST_OUTSEL      16'h0000
`define CPM_RST_PUD         8'hFF
`define CPM_RST_ENABLE      8'h00
`define CPM_RST_DIR         8'h00
`define CPM_RST_DATA        8'h00

// ==========================================================================
// Field layout: two select bits per pin, pin n at bits 2n+1..2n
// ==========================================================================
`define CPM_SEL_W           2

`endif

// File: include/cpm_pkg.sv
package cpm_pkg;

    typedef enum logic [1:0]
    {
        CPM_MODE_GPIO  = 2'b00,
        CPM_MODE_RSV1  = 2'b01,
        CPM_MODE_RSV2  = 2'b10,
        CPM_MODE_COMP  = 2'b11
    } cpm_mode_e;

    typedef logic [7:0] cpm_pins_t;

endpackage

// File: core/cpm_comparator_pin_mux.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "cpm_map.svh"

// Operation
// - Eight pins: GPIO in, out, or comparator; pins 0 and 6 have no comparator here.
// - Pullup disabled while its disable bit is one.
// - Reset leaves every pin analog, GPIO disabled.
// - Only control CPU may program the registers.
// - Two-bit field per pin selects mode 0-3.
// - Mode 0 connects pin to its GPIO.
// - Modes 1 and 2 give no function.
// - Mode 3 routes the fixed comparator to pins.
// - Readable writable data and direction per pin.
module cpm_comparator_pin_mux
(
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    input  wire logic [`CPM_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`CPM_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic                     reg_from_control_cpu_i,
    output logic      [`CPM_DATA_W-1:0]   reg_rdata_o,
    input  wire logic                     comparator1_output_i,
    input  wire logic                     comparator2_output_i,
    input  wire logic                     comparator3_output_i,
    input  wire logic                     comparator4_output_i,
    input  wire logic                     comparator5_output_i,
    input  wire logic                     comparator6_output_i,
    input  wire logic [`CPM_PINS-1:0]     mux_pin_in_i,
    output logic      [`CPM_PINS-1:0]     mux_pin_out_o,
    output logic      [`CPM_PINS-1:0]     mux_pin_oe_o,
    output logic      [`CPM_PINS-1:0]     mux_pin_pullup_en_o,
    output logic      [`CPM_PINS-1:0]     mux_pin_analog_o
);

    // ======================================================================
    // Helpers
    // ======================================================================
    // Both the pin driver and the data readback need each pin's mode.
    function automatic cpm_pkg::cpm_mode_e pin_mode
    (
        input logic [`CPM_DATA_W-1:0] sel,
        input int                     pin
    );
        pin_mode = cpm_pkg::cpm_mode_e'(sel[2*pin +: `CPM_SEL_W]);
    endfunction

    // ======================================================================
    // Register storage
    // ======================================================================
    logic [`CPM_DATA_W-1:0]   output_select_reg;
    logic [`CPM_DATA_W-1:0]   output_select_next;
    cpm_pkg::cpm_pins_t       pullup_disable_reg;
    cpm_pkg::cpm_pins_t       pullup_disable_next;
    cpm_pkg::cpm_pins_t       gpio_enable_reg;
    cpm_pkg::cpm_pins_t       gpio_enable_next;
    cpm_pkg::cpm_pins_t       direction_reg;
    cpm_pkg::cpm_pins_t       direction_next;
    cpm_pkg::cpm_pins_t       data_out_reg;
    cpm_pkg::cpm_pins_t       data_out_next;
    logic [`CPM_DATA_W-1:0]   rdata_reg;
    logic [`CPM_DATA_W-1:0]   rdata_next;

    // ======================================================================
    // Pin input synchronisers
    // ======================================================================
    cpm_pkg::cpm_pins_t       pin_meta_reg;
    cpm_pkg::cpm_pins_t       pin_s2_reg;
    cpm_pkg::cpm_pins_t       pin_s3_reg;
    cpm_pkg::cpm_pins_t       pin_level_reg;
    cpm_pkg::cpm_pins_t       pin_level_next;

    // A level is accepted only once the second and third stages agree, which
    // costs a cycle of latency but filters a single-cycle glitch.
    assign pin_level_next = (pin_s2_reg & pin_s3_reg) | (pin_level_reg & (pin_s2_reg | pin_s3_reg));

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pin_meta_reg  <= 8'h00;
            pin_s2_reg    <= 8'h00;
            pin_s3_reg    <= 8'h00;
            pin_level_reg <= 8'h00;
        end
        else
        begin
            pin_meta_reg  <= mux_pin_in_i;
            pin_s2_reg    <= pin_meta_reg;
            pin_s3_reg    <= pin_s2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    // ======================================================================
    // Register access decode
    // ======================================================================
    wire                      wr_ok;
    wire                      rd_ok;
    wire                      hit_outsel;
    wire                      hit_pud;
    wire                      hit_enable;
    wire                      hit_dir;
    wire                      hit_data;
    wire                      hit_set;
    wire                      hit_clear;
    wire                      hit_toggle;
    wire [7:0]                wbyte;

    // Accesses tagged as coming from the other processor are dropped here.
    assign wr_ok      = reg_wr_i & reg_from_control_cpu_i;
    assign rd_ok      = reg_rd_i & reg_from_control_cpu_i;
    assign hit_outsel = (reg_addr_i == `CPM_OFS_OUTSEL);
    assign hit_pud    = (reg_addr_i == `CPM_OFS_PUD);
    assign hit_enable = (reg_addr_i == `CPM_OFS_ENABLE);
    assign hit_dir    = (reg_addr_i == `CPM_OFS_DIR);
    assign hit_data   = (reg_addr_i == `CPM_OFS_DATA);
    assign hit_set    = (reg_addr_i == `CPM_OFS_SET);
    assign hit_clear  = (reg_addr_i == `CPM_OFS_CLEAR);
    assign hit_toggle = (reg_addr_i == `CPM_OFS_TOGGLE);
    assign wbyte      = reg_wdata_i[7:0];

    assign output_select_next  = (wr_ok & hit_outsel) ? reg_wdata_i : output_select_reg;
    assign pullup_disable_next = (wr_ok & hit_pud)    ? wbyte : pullup_disable_reg;
    assign gpio_enable_next    = (wr_ok & hit_enable) ? wbyte : gpio_enable_reg;
    assign direction_next      = (wr_ok & hit_dir)    ? wbyte : direction_reg;

    // Set, clear and toggle let software change single bits without a
    // read-modify-write race against another task.
    assign data_out_next = !wr_ok     ? data_out_reg :
                           hit_data   ? wbyte :
                           hit_set    ? (data_out_reg | wbyte) :
                           hit_clear  ? (data_out_reg & ~wbyte) :
                           hit_toggle ? (data_out_reg ^ wbyte) :
                                        data_out_reg;

    // ======================================================================
    // Data readback
    // ======================================================================
    cpm_pkg::cpm_pins_t       data_view;
    cpm_pkg::cpm_pins_t       gpio_active;

    // An output pin reads back its latch, an input pin its filtered level;
    // a pin not in GPIO mode reads zero.
    always_comb
    begin
        for (int i = 0; i < `CPM_PINS; i++)
        begin
            gpio_active[i] = gpio_enable_reg[i] && (pin_mode(output_select_reg, i) == cpm_pkg::CPM_MODE_GPIO);
            data_view[i]   = gpio_active[i] & (direction_reg[i] ? data_out_reg[i] : pin_level_reg[i]);
        end
    end

    assign rdata_next = !rd_ok      ? 16'h0000 :
                        hit_outsel  ? output_select_reg :
                        hit_pud     ? {8'h00, pullup_disable_reg} :
                        hit_enable  ? {8'h00, gpio_enable_reg} :
                        hit_dir     ? {8'h00, direction_reg} :
                        hit_data    ? {8'h00, data_view} :
                                      16'h0000;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            output_select_reg  <= `CPM_RST_OUTSEL;
            pullup_disable_reg <= `CPM_RST_PUD;
            gpio_enable_reg    <= `CPM_RST_ENABLE;
            direction_reg      <= `CPM_RST_DIR;
            data_out_reg       <= `CPM_RST_DATA;
            rdata_reg          <= 16'h0000;
        end
        else
        begin
            output_select_reg  <= output_select_next;
            pullup_disable_reg <= pullup_disable_next;
            gpio_enable_reg    <= gpio_enable_next;
            direction_reg      <= direction_next;
            data_out_reg       <= data_out_next;
            rdata_reg          <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ======================================================================
    // Pin function selection
    // ======================================================================
    cpm_pkg::cpm_pins_t       comp_route;
    cpm_pkg::cpm_pins_t       comp_present;
    cpm_pkg::cpm_pins_t       pin_out_next;
    cpm_pkg::cpm_pins_t       pin_oe_next;
    cpm_pkg::cpm_pins_t       pin_analog_next;
    cpm_pkg::cpm_pins_t       pin_out_reg;
    cpm_pkg::cpm_pins_t       pin_oe_reg;
    cpm_pkg::cpm_pins_t       pin_analog_reg;
    cpm_pkg::cpm_pins_t       pin_pullup_reg;

    // Pins 0 and 6 have no comparator behind them.
    assign comp_route = {comparator5_output_i, 1'b0, comparator4_output_i, comparator3_output_i,
                         comparator2_output_i, comparator6_output_i, comparator1_output_i, 1'b0};
    assign comp_present = 8'hBE;

    always_comb
    begin
        for (int i = 0; i < `CPM_PINS; i++)
        begin
            pin_out_next[i]    = 1'b0;
            pin_oe_next[i]     = 1'b0;
            pin_analog_next[i] = 1'b1;
            if (gpio_enable_reg[i])
            begin
                unique case (pin_mode(output_select_reg, i))
                    cpm_pkg::CPM_MODE_GPIO:
                    begin
                        pin_analog_next[i] = 1'b0;
                        pin_oe_next[i]     = direction_reg[i];
                        pin_out_next[i]    = data_out_reg[i];
                    end
                    cpm_pkg::CPM_MODE_RSV1,
                    cpm_pkg::CPM_MODE_RSV2:
                    begin
                        pin_analog_next[i] = 1'b0;
                    end
                    cpm_pkg::CPM_MODE_COMP:
                    begin
                        pin_analog_next[i] = 1'b0;
                        pin_oe_next[i]     = comp_present[i];
                        pin_out_next[i]    = comp_route[i];
                    end
                endcase
            end
        end
    end

    // Registered so that the pad sees one clean edge per change, at the
    // price of one cycle between a register write and the pin.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pin_out_reg    <= 8'h00;
            pin_oe_reg     <= 8'h00;
            pin_analog_reg <= 8'hFF;
            pin_pullup_reg <= 8'h00;
        end
        else
        begin
            pin_out_reg    <= pin_out_next;
            pin_oe_reg     <= pin_oe_next;
            pin_analog_reg <= pin_analog_next;
            pin_pullup_reg <= ~pullup_disable_reg;
        end
    end

    assign mux_pin_out_o       = pin_out_reg;
    assign mux_pin_oe_o        = pin_oe_reg;
    assign mux_pin_analog_o    = pin_analog_reg;
    assign mux_pin_pullup_en_o = pin_pullup_reg;

endmodule // cpm_comparator_pin_mux

// File: tb/cpm_far_side.sv
`timescale 1ns/1ps
// ====
// Pads and comparators
module cpm_far_side
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] pullup_en_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [5:0] cmp_val_i,
    output logic      [7:0] pad_o,
    output logic      [5:0] cmp_o
);
    logic [7:0] float_reg = 8'h00;
    // An undriven pad without pullup wanders, so no steady level can be relied on.
    always_ff @(posedge mclk_i)
        float_reg <= ~float_reg;
    assign pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                 | (~pin_oe_i & ~ext_en_i & (pullup_en_i | float_reg));
    assign cmp_o = cmp_val_i;
endmodule // cpm_far_side

// File: tb/cpm_pin_mux_chk.sv
`timescale 1ns/1ps
`include "cpm_map.svh"
// ====
// Port checker
module cpm_pin_mux_chk
(
    input wire logic                   mclk_i,
    input wire logic                   rst_i,
    input wire logic [`CPM_ADDR_W-1:0] reg_addr_i,
    input wire logic [`CPM_DATA_W-1:0] reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic                   reg_from_control_cpu_i,
    input wire logic [`CPM_DATA_W-1:0] reg_rdata_o,
    input wire logic                   comparator1_output_i,
    input wire logic                   comparator2_output_i,
    input wire logic                   comparator3_output_i,
    input wire logic                   comparator4_output_i,
    input wire logic                   comparator5_output_i,
    input wire logic                   comparator6_output_i,
    input wire logic [`CPM_PINS-1:0]   mux_pin_in_i,
    input wire logic [`CPM_PINS-1:0]   mux_pin_out_o,
    input wire logic [`CPM_PINS-1:0]   mux_pin_oe_o,
    input wire logic [`CPM_PINS-1:0]   mux_pin_pullup_en_o,
    input wire logic [`CPM_PINS-1:0]   mux_pin_analog_o
);
    logic [15:0] sel_reg;
    logic [7:0]  pud_reg, en_reg, dir_reg, dat_reg, m0, m3;
    wire  [7:0]  wd = reg_wdata_i[7:0];
    wire  [7:0]  cmp_v = {comparator5_output_i, 1'h0, comparator4_output_i, comparator3_output_i,
                          comparator2_output_i, comparator6_output_i, comparator1_output_i, 1'h0};
    wire  [7:0]  x_oe = (m0 & dir_reg) | (m3 & 8'hBE);
    wire  [7:0]  x_out = (m0 & dir_reg & dat_reg) | (m3 & 8'hBE & cmp_v);
    wire  [15:0] view = (reg_addr_i == `CPM_OFS_OUTSEL) ? sel_reg : {8'h00, (reg_addr_i == `CPM_OFS_PUD) ?
                        pud_reg : (reg_addr_i == `CPM_OFS_ENABLE) ? en_reg : dir_reg};
    always_comb
        for (int i = 0; i < 8; i++)
        begin
            m0[i] = en_reg[i] && sel_reg[2*i+:2] == 2'h0;
            m3[i] = en_reg[i] && sel_reg[2*i+:2] == 2'h3;
        end
    always_ff @(posedge mclk_i)
        if (rst_i)
            {sel_reg, pud_reg, en_reg, dir_reg, dat_reg} <= {16'h0000, 8'hFF, 24'h000000};
        else if (reg_wr_i && reg_from_control_cpu_i)
            case (reg_addr_i)
                `CPM_OFS_OUTSEL: sel_reg <= reg_wdata_i;
                `CPM_OFS_PUD:    pud_reg <= wd;
                `CPM_OFS_ENABLE: en_reg <= wd;
                `CPM_OFS_DIR:    dir_reg <= wd;
                `CPM_OFS_DATA:   dat_reg <= wd;
                `CPM_OFS_SET:    dat_reg <= dat_reg | wd;
                `CPM_OFS_CLEAR:  dat_reg <= dat_reg & ~wd;
                `CPM_OFS_TOGGLE: dat_reg <= dat_reg ^ wd;
                default: ;
            endcase
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_cfg_rd; reg_rd_i && reg_from_control_cpu_i && reg_addr_i <= `CPM_OFS_DIR; endsequence
    sequence s_wo_rd; reg_rd_i && reg_from_control_cpu_i && reg_addr_i > `CPM_OFS_DATA; endsequence
    property p_rd_cfg; s_cfg_rd |=> reg_rdata_o == $past(view); endproperty
    property p_rd_wo; s_wo_rd |=> reg_rdata_o == 16'h0000; endproperty
    property p_rd_foreign; reg_rd_i && !reg_from_control_cpu_i |=> reg_rdata_o == 16'h0000; endproperty
    property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
    property p_reset; $fell(rst_i) |-> mux_pin_analog_o == 8'hFF && mux_pin_oe_o == 8'h00; endproperty
    // The edge that still resets the block and the one after it are skipped, since the
    // release is seen by the disable before the block has left reset.
    property p_analog; !rst_i && !$past(rst_i) |-> mux_pin_analog_o == ~$past(en_reg); endproperty
    property p_oe; !rst_i && !$past(rst_i) |-> mux_pin_oe_o == $past(x_oe); endproperty
    property p_out; !rst_i && !$past(rst_i) |-> (mux_pin_out_o & $past(x_oe)) == $past(x_out & x_oe); endproperty
    property p_pullup; !rst_i && !$past(rst_i) |-> mux_pin_pullup_en_o == ~$past(pud_reg); endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("config readback wrong");
    a_rd_wo: assert property (p_rd_wo) else $error("write-only read not zero");
    a_rd_foreign: assert property (p_rd_foreign) else $error("foreign read not zero");
    a_rd_idle: assert property (p_rd_idle) else $error("idle read data not zero");
    a_reset: assert property (p_reset) else $error("pins not analog after reset");
    a_analog: assert property (p_analog) else $error("analog state wrong");
    a_oe: assert property (p_oe) else $error("output enable wrong");
    a_out: assert property (p_out) else $error("pin output wrong");
    a_pullup: assert property (p_pullup) else $error("pullup enable wrong");
endmodule // cpm_pin_mux_chk
bind cpm_comparator_pin_mux cpm_pin_mux_chk i_cpm_pin_mux_chk (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_from_control_cpu_i, .reg_rdata_o, .comparator1_output_i, .comparator2_output_i,
    .comparator3_output_i, .comparator4_output_i, .comparator5_output_i, .comparator6_output_i,
    .mux_pin_in_i, .mux_pin_out_o, .mux_pin_oe_o, .mux_pin_pullup_en_o, .mux_pin_analog_o);

// File: tb/testbench.sv
`timescale 1ns/1ps
// ====
// Bench
module testbench;
    typedef struct packed { logic [3:0] a; logic [15:0] d; logic [15:0] e; } cpm_row_s;
    cpm_row_s rows [6] = '{'{4'h0, 16'hFFFF, 16'hFFFF}, '{4'h0, 16'h5A3C, 16'h5A3C}, '{4'h1, 16'h00A5, 16'h00A5},
                           '{4'h1, 16'hFF0F, 16'h000F}, '{4'h2, 16'h00C3, 16'h00C3}, '{4'h3, 16'h003C, 16'h003C}};
    logic [15:0] rstv [5] = '{16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h0000};
    logic        mclk_i = 1'h0, rst_i = 1'h1, wr = 1'h0, rd = 1'h0, cpu = 1'h1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0]  pout, poe, pup, pan, pad, ext_en = 8'h00, ext_val = 8'h00, p;
    logic [5:0]  cmp_val = 6'h00, cmp;
    int          error_cnt = 0, checked = 0, cyc = 0;
    cpm_comparator_pin_mux i_cpm_comparator_pin_mux (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_from_control_cpu_i(cpu), .reg_rdata_o(rdata),
        .comparator1_output_i(cmp[0]), .comparator2_output_i(cmp[1]), .comparator3_output_i(cmp[2]),
        .comparator4_output_i(cmp[3]), .comparator5_output_i(cmp[4]), .comparator6_output_i(cmp[5]),
        .mux_pin_in_i(pad), .mux_pin_out_o(pout), .mux_pin_oe_o(poe), .mux_pin_pullup_en_o(pup),
        .mux_pin_analog_o(pan));
    cpm_far_side i_cpm_far_side (.mclk_i(mclk_i), .pin_out_i(pout), .pin_oe_i(poe), .pullup_en_i(pup),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .cmp_val_i(cmp_val), .pad_o(pad), .cmp_o(cmp));
    initial
    begin
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        {addr, wdata, wr} <= {a, d, 1'h1};
        @(posedge mclk_i);
        wr <= 1'h0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        {addr, rd} <= {a, 1'h1};
        @(posedge mclk_i);
        rd <= 1'h0;
        #1 chk(rdata, e);
    endtask
    task automatic pins(input logic [7:0] e_oe, input logic [7:0] e_out, input logic [7:0] e_an);
        repeat (2) @(posedge mclk_i);
        #1 chk(poe, e_oe);
        chk(pout & e_oe, e_out);
        chk(pan, e_an);
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A hang is cut short well past the roughly 140 cycles the sequence needs.
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            complete_run;
        end
    end
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'h0;
        pins(8'h00, 8'h00, 8'hFF);
        chk(pup, 8'h00);
        for (int i = 0; i < 5; i++)
            rdc(i[3:0], rstv[i]);
        foreach (rows[i])
        begin
            wrt(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        chk(pup, 8'hF0);
        @(posedge mclk_i) cpu <= 1'h0;
        wrt(4'h2, 16'h00FF);
        rdc(4'h2, 16'h0000);
        @(posedge mclk_i) cpu <= 1'h1;
        rdc(4'h2, 16'h00C3);
        wrt(4'h8, 16'hFFFF);
        rdc(4'h8, 16'h0000);
        rdc(4'h5, 16'h0000);
        wrt(4'h0, 16'h0000);
        wrt(4'h2, 16'h00FF);
        wrt(4'h3, 16'h00F0);
        wrt(4'h4, 16'h00A5);
        pins(8'hF0, 8'hA0, 8'h00);
        wrt(4'h5, 16'h0002);
        wrt(4'h6, 16'h0080);
        wrt(4'h7, 16'h00FF);
        pins(8'hF0, 8'hD0, 8'h00);
        @(posedge mclk_i) {ext_en, ext_val} <= {8'hFF, 8'h09};
        repeat (8) @(posedge mclk_i);
        rdc(4'h4, 16'h00D9);
        wrt(4'h3, 16'h00FF);
        wrt(4'h0, 16'h0030);
        cmp_val <= 6'h20;
        pins(8'hFF, 8'hDC, 8'h00);
        wrt(4'h0, 16'hFFFF);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge mclk_i) cmp_val <= k ? 6'h2A : 6'h15;
            p = {k ? 8'h2A : 8'h15};
            pins(8'hBE, {p[4], 1'h0, p[3], p[2], p[1], p[5], p[0], 1'h0}, 8'h00);
        end
        rdc(4'h4, 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            wrt(4'h0, k ? 16'hAAAA : 16'h5555);
            pins(8'h00, 8'h00, 8'h00);
        end
        wrt(4'h2, 16'h0000);
        pins(8'h00, 8'h00, 8'hFF);
        wrt(4'h2, 16'h00FF);
        wrt(4'h0, 16'h0000);
        @(posedge mclk_i) rst_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'h0;
        pins(8'h00, 8'h00, 8'hFF);
        rdc(4'h2, 16'h0000);
        wrt(4'h2, 16'h00FF);
        wrt(4'h3, 16'h00FF);
        pins(8'hFF, 8'h00, 8'h00);
        complete_run;
    end
endmodule // testbench
